// File: ncd_defines.vh
`ifndef NCD_DEFINES_VH
`define NCD_DEFINES_VH
// Register byte offsets on the Avalon-MM slave.
`define NCD_ADDR_W            4
`define NCD_OFF_DIVIDE        4'h0
`define NCD_OFF_OPCTRL        4'h4
`define NCD_OFF_OPSTAT        4'h8
// Divide setting register fields.
`define NCD_LOADED_BIT        7
`define NCD_PRESCALE_BIT      6
`define NCD_DIV_MSB           5
`define NCD_DIVIDE_RST        8'h00
// Prescaler ratio minus one, for the divide-by-eight stage.
`define NCD_PRESCALE_LAST     3'h7
// Timing pulse window in nanoseconds, for software setting checks.
`define NCD_PULSE_MIN_NS      5000
`define NCD_PULSE_MAX_NS      6700
`define NCD_CLK_PERIOD_NS     8
// Pulse window expressed in bus cycles, rounded up for the least and down for the longest.
`define NCD_PULSE_MIN_CYC     ((`NCD_PULSE_MIN_NS + `NCD_CLK_PERIOD_NS - 1) / `NCD_CLK_PERIOD_NS)
`define NCD_PULSE_MAX_CYC     (`NCD_PULSE_MAX_NS / `NCD_CLK_PERIOD_NS)
// Unmapped reads return this value.
`define NCD_UNMAPPED_DATA     32'h00000000
`endif

// File: ncd_nvm_clock_divider.v
`timescale 1ns/1ps
`include "ncd_defines.vh"

// Operation
// - Loaded flag is read-only, write data never touch it.
// - Low seven bits writable, first write only.
// - Reset clears flag; first write sets it.
// - Flag low blocks program and erase operations.
// - Prescale bit selects bus clock or clock/8.
// - Divide selected input by divisor plus one.
// - Each timing pulse lasts one memory clock period per count of the operation length; a length of zero runs one period.
// - Sequencer times operations in whole memory periods.
// - Divide setting is an eight-bit register.
module ncd_nvm_clock_divider (
  input  wire                     sys_clk_i,
  input  wire                     srst_i,
  input  wire [`NCD_ADDR_W-1:0]   avs_address_i,
  input  wire                     avs_read_i,
  input  wire                     avs_write_i,
  input  wire [31:0]              avs_writedata_i,
  input  wire [3:0]               avs_byteenable_i,
  output reg  [31:0]              avs_readdata_o,
  output reg                      avs_waitrequest_o,
  input  wire                     op_req_i,
  input  wire [15:0]              op_len_i,
  output reg                      nvm_tick_o,
  output reg                      op_grant_o,
  output reg                      op_pulse_o,
  output reg                      op_busy_o,
  output reg                      op_done_o,
  output reg                      op_blocked_o
);

  // Register map, one byte per word in the low lane:
  //   divide setting : bit 7 loaded flag (read only), bit 6 prescale, bits 5..0 divisor.
  //   operation ctrl : bit 0 written as one starts a timed operation.
  //   operation stat : bit 2 last request refused, bit 1 busy, bit 0 loaded.
  // The memory clock window cannot be met at a 125 MHz bus clock: the slowest setting,
  // prescale with divisor 63, gives a 4.096 us period. The divider still follows the
  // rule exactly, so the same logic serves slower bus clocks unchanged.

  // Sequencer states, one-hot. The align state waits for a period boundary so that the
  // pulse never starts in the middle of a memory clock period.
  localparam [2:0] ST_IDLE  = 3'h1;
  localparam [2:0] ST_ALIGN = 3'h2;
  localparam [2:0] ST_RUN   = 3'h4;

  // Stored setting, divider counters and sequencer state.
  reg  [7:0]  divide_setting_r;
  reg  [2:0]  pre_cnt_r;
  reg  [5:0]  div_cnt_r;
  reg  [2:0]  state_r;
  reg  [15:0] pulses_left_r;
  reg         start_sw_r;
  reg  [31:0] rdata_nxt;

  // Fields of the setting, and the per-cycle strobes derived from it. The tick is
  // gated by the loaded flag so nothing downstream moves before software has set up.
  wire        prescale_by_eight  = divide_setting_r[`NCD_PRESCALE_BIT];
  wire [5:0]  divisor_field_bits = divide_setting_r[`NCD_DIV_MSB:0];
  wire        divisor_loaded     = divide_setting_r[`NCD_LOADED_BIT];
  wire        bus_hit            = (avs_read_i | avs_write_i) & avs_waitrequest_o;
  wire        wr_hit             = avs_write_i & avs_waitrequest_o;
  wire        pre_tick           = ~prescale_by_eight | (pre_cnt_r == `NCD_PRESCALE_LAST);
  wire        div_wrap           = pre_tick & (div_cnt_r == divisor_field_bits);
  wire        tick               = div_wrap & divisor_loaded;

  // Returns 1 when the access targets the given byte offset.
  function is_addr;
    input [`NCD_ADDR_W-1:0] a;
    input [`NCD_ADDR_W-1:0] off;
    begin
      is_addr = (a == off);
    end
  endfunction

  // An operation length of zero is run as a single period so a request always completes.
  function [15:0] op_count;
    input [15:0] len;
    begin
      op_count = (len == 16'h0000) ? 16'h0001 : len;
    end
  endfunction

  // Write strobes per location; only byte lane zero carries register data, so a write
  // without it is dropped rather than loading a stale byte.
  wire        wr_divide          = wr_hit & avs_byteenable_i[0] &
                                   is_addr(avs_address_i, `NCD_OFF_DIVIDE);
  wire        wr_opctrl          = wr_hit & avs_byteenable_i[0] &
                                   is_addr(avs_address_i, `NCD_OFF_OPCTRL);

  // One wait cycle per access keeps every answer registered and the timing simple.
  // The master must release at the answer edge; a request still standing one edge
  // later is taken as a new access.
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= ~bus_hit;
    end
  end

  // The setting takes only the first write after reset; the flag is never written from data.
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      divide_setting_r <= `NCD_DIVIDE_RST;
    end else if (wr_divide && !divisor_loaded) begin
      divide_setting_r <= {1'b1, avs_writedata_i[6:0]};
    end
  end

  // Software start request for a timed operation, cleared once taken.
  // A start written while an operation runs is held and begins once the sequencer idles.
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      start_sw_r <= 1'b0;
    end else if (wr_opctrl && avs_writedata_i[0]) begin
      start_sw_r <= 1'b1;
    end else if (state_r == ST_IDLE) begin
      start_sw_r <= 1'b0;
    end
  end

  // Read mux; unused bits read zero.
  always @* begin
    rdata_nxt = `NCD_UNMAPPED_DATA;
    if (is_addr(avs_address_i, `NCD_OFF_DIVIDE)) begin
      rdata_nxt = {24'h000000, divide_setting_r};
    end else if (is_addr(avs_address_i, `NCD_OFF_OPSTAT)) begin
      rdata_nxt = {29'h0, op_blocked_o, op_busy_o, divisor_loaded};
    end
  end

  // Read data are captured on the taking edge and stand at the answer edge.
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      avs_readdata_o <= 32'h00000000;
    end else if (avs_read_i && avs_waitrequest_o) begin
      avs_readdata_o <= rdata_nxt;
    end
  end

  // Counters on the bus clock produce an enable instead of a derived clock net.
  // Both hold at zero until the setting is loaded, so the first tick comes one full
  // period after the write.
  always @(posedge sys_clk_i) begin
    if (srst_i || !divisor_loaded) begin
      pre_cnt_r <= 3'h0;
      div_cnt_r <= 6'h00;
    end else begin
      pre_cnt_r <= prescale_by_eight ? pre_cnt_r + 3'h1 : 3'h0;
      if (pre_tick) begin
        div_cnt_r <= div_wrap ? 6'h00 : div_cnt_r + 6'h01;
      end
    end
  end

  // Operation sequencer counts whole memory clock periods; a request while not loaded is refused.
  // A request first waits for a divider tick, so the pulse spans only whole periods;
  // starting in mid-period would shorten the first one.
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      state_r       <= ST_IDLE;
      pulses_left_r <= 16'h0000;
      nvm_tick_o    <= 1'b0;
      op_grant_o    <= 1'b0;
      op_pulse_o    <= 1'b0;
      op_busy_o     <= 1'b0;
      op_done_o     <= 1'b0;
      op_blocked_o  <= 1'b0;
    end else begin
      nvm_tick_o <= tick;
      op_grant_o <= divisor_loaded;
      op_done_o  <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          op_pulse_o <= 1'b0;
          op_busy_o  <= 1'b0;
          if (op_req_i || start_sw_r) begin
            if (!divisor_loaded) begin
              op_blocked_o <= 1'b1;
            end else begin
              op_blocked_o  <= 1'b0;
              pulses_left_r <= op_count(op_len_i);
              state_r       <= ST_ALIGN;
              op_busy_o     <= 1'b1;
            end
          end
        end
        ST_ALIGN: begin
          // The pulse opens on a period boundary and holds one full period per count.
          if (tick) begin
            state_r    <= ST_RUN;
            op_pulse_o <= 1'b1;
          end
        end
        ST_RUN: begin
          if (tick) begin
            if (pulses_left_r == 16'h0001) begin
              state_r    <= ST_IDLE;
              op_pulse_o <= 1'b0;
              op_busy_o  <= 1'b0;
              op_done_o  <= 1'b1;
            end
            pulses_left_r <= pulses_left_r - 16'h0001;
          end
        end
        default: begin
          state_r    <= ST_IDLE;
          op_pulse_o <= 1'b0;
          op_busy_o  <= 1'b0;
        end
      endcase
    end
  end

endmodule // ncd_nvm_clock_divider

// File: ncd_asserts.sv
`timescale 1ns/1ps
// Bus answer timing and operation gating, seen only at the ports.
module ncd_asserts (
  input wire sys_clk_i,
  input wire srst_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire avs_waitrequest_o,
  input wire nvm_tick_o,
  input wire op_grant_o,
  input wire op_pulse_o,
  input wire op_busy_o,
  input wire op_done_o,
  input wire op_blocked_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  // Any access request, read or write.
  wire req = avs_read_i | avs_write_i;
  // An access is answered after one wait cycle, and the answer lasts one cycle.
  property p_ans; req && avs_waitrequest_o |=> !avs_waitrequest_o; endproperty
  a_ans: assert property (p_ans) else $error("access not answered");
  property p_one; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
  a_one: assert property (p_one) else $error("answer held too long");
  property p_cause; $fell(avs_waitrequest_o) |-> $past(req); endproperty
  a_cause: assert property (p_cause) else $error("answer without access");
  // The loaded flag falls only by reset, and nothing runs without it.
  property p_keep; op_grant_o |=> op_grant_o; endproperty
  a_keep: assert property (p_keep) else $error("loaded flag lost");
  property p_gate; op_busy_o || op_pulse_o |-> op_grant_o; endproperty
  a_gate: assert property (p_gate) else $error("operation while unloaded");
  property p_tick; nvm_tick_o |-> op_grant_o; endproperty
  a_tick: assert property (p_tick) else $error("tick while unloaded");
  property p_pulse; op_pulse_o |-> op_busy_o; endproperty
  a_pulse: assert property (p_pulse) else $error("pulse outside operation");
  property p_done; op_done_o |=> !op_done_o; endproperty
  a_done: assert property (p_done) else $error("done longer than one cycle");
  property p_blk; op_blocked_o |-> !op_busy_o; endproperty
  a_blk: assert property (p_blk) else $error("blocked while busy");
  // Pulse edges fall on memory clock period boundaries only.
  property p_edge; $rose(op_pulse_o) || $fell(op_pulse_o) |-> nvm_tick_o; endproperty
  a_edge: assert property (p_edge) else $error("pulse edge off a period boundary");
  c_op: cover property (op_done_o);
  c_blk: cover property (op_blocked_o);
  c_tick: cover property (nvm_tick_o ##1 !nvm_tick_o);
endmodule // ncd_asserts
bind ncd_nvm_clock_divider ncd_asserts u_chk (
  .sys_clk_i(sys_clk_i), .srst_i(srst_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
  .nvm_tick_o(nvm_tick_o), .op_grant_o(op_grant_o), .op_pulse_o(op_pulse_o),
  .op_busy_o(op_busy_o), .op_done_o(op_done_o), .op_blocked_o(op_blocked_o));

// File: test_nvm_clock_divider.sv
`timescale 1ns/1ps
`include "ncd_defines.vh"
// Drives bus and operation request; read results are checked through a queue.
module test_nvm_clock_divider;
  logic        clk = 0, rst = 1, rd = 0, wr = 0, req = 0, wt, tk, gr, pu, bz, dn, bl;
  logic [3:0]  a = 4'h0;
  logic [31:0] wd = 32'h0, rdat, q[$];
  logic [15:0] len = 16'h0001;
  int          n_mismatch = 0, checks = 0, n, t, i, v, p, k;
  always #4 clk = ~clk;
  ncd_nvm_clock_divider dut_u (.sys_clk_i(clk), .srst_i(rst), .avs_address_i(a),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wt), .op_req_i(req), .op_len_i(len),
    .nvm_tick_o(tk), .op_grant_o(gr), .op_pulse_o(pu), .op_busy_o(bz),
    .op_done_o(dn), .op_blocked_o(bl));
  task automatic chk(string s, logic [31:0] g, logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s exp %h seen %h", s, e, g);
    end
  endtask
  task end_sim;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // One bounded clock step; a wait that runs out ends the run as a failure.
  task step;
    @(posedge clk);
    n++;
    if (n > 3000) begin
      n_mismatch++;
      end_sim();
    end
  endtask
  // The request is held until the edge that samples waitrequest low.
  task bus(logic w, logic [3:0] ad, logic [31:0] d);
    rd <= !w; wr <= w; a <= ad; wd <= d; n = 0;
    do step(); while (wt !== 1'b0);
    rd <= 1'b0; wr <= 1'b0; @(posedge clk);
  endtask
  task rdq(logic [3:0] ad, logic [31:0] e);
    q.push_back(e);
    bus(1'b0, ad, 32'h0);
  endtask
  // Read data are taken at the answer edge and matched to the oldest note.
  always @(posedge clk) if (wt === 1'b0 && rd === 1'b1) chk("readdata", rdat, q.pop_front());
  initial begin
    v = $urandom(86);
    for (i = 0; i < 2; i++) begin
      rst <= 1'b1; repeat (6) @(posedge clk); rst <= 1'b0;
      req <= 1'b1; @(posedge clk); req <= 1'b0; repeat (3) @(posedge clk);
      chk("refused op", {gr, bz, bl}, 3'b001);
      rdq(`NCD_OFF_OPSTAT, 32'h4);
      rdq(`NCD_OFF_DIVIDE, 32'h0);
      // Bit 7 is written as zero so a readback of one shows the flag is not data.
      v = $urandom;
      v[6] = i[0];
      v[7] = 1'b0;
      // The second run uses the slowest setting, nearest the memory clock window here.
      if (i[0]) v[5:0] = 6'h3F;
      bus(1'b1, `NCD_OFF_DIVIDE, v);
      rdq(`NCD_OFF_DIVIDE, {24'h0, 1'b1, v[6:0]});
      bus(1'b1, `NCD_OFF_DIVIDE, ~v);
      rdq(`NCD_OFF_DIVIDE, {24'h0, 1'b1, v[6:0]});
      rdq(4'hC, 32'h0);
      p = (v[5:0] + 1) * (v[6] ? 8 : 1);
      n = 0; while (tk !== 1'b1) step();
      n = 0; do step(); while (tk !== 1'b1);
      chk("tick period", n, p);
      len <= 16'($urandom_range(1, 3));
      if (i[0]) begin
        bus(1'b1, `NCD_OFF_OPCTRL, 32'h1);
      end else begin
        req <= 1'b1;
        @(posedge clk);
        req <= 1'b0;
      end
      n = 0; t = 0; k = 0;
      while (dn !== 1'b1) begin
        step();
        t += pu;
        k += tk & pu;
      end
      chk("op periods", k, len);
      chk("pulse width", t, len * p);
      chk("grant", gr, 1'b1);
      rdq(`NCD_OFF_OPSTAT, 32'h1);
    end
    end_sim();
  end
endmodule // test_nvm_clock_divider
